// File: hw/asp_pkg.sv
// shared constants and types of the audio serial port control block
package asp_pkg;
  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          CNT_W         = 16;
  // register offsets
  localparam logic [11:0] OFS_START     = 12'h000;
  localparam logic [11:0] OFS_STOP      = 12'h004;
  localparam logic [11:0] OFS_EV_RXUPD  = 12'h104;
  localparam logic [11:0] OFS_EV_STOP   = 12'h108;
  localparam logic [11:0] OFS_EV_TXUPD  = 12'h114;
  localparam logic [11:0] OFS_IRQ_WORD  = 12'h300;
  localparam logic [11:0] OFS_IRQ_SET   = 12'h304;
  localparam logic [11:0] OFS_IRQ_CLR   = 12'h308;
  localparam logic [11:0] OFS_ENABLE    = 12'h500;
  localparam logic [11:0] OFS_ROLE      = 12'h504;
  localparam logic [11:0] OFS_RECEIVE_ENABLE      = 12'h508;
  localparam logic [11:0] OFS_TRANSMIT_ENABLE      = 12'h50c;
  localparam logic [11:0] OFS_MASTER_CLOCK_ENABLE     = 12'h510;
  localparam logic [11:0] OFS_MCKDIV    = 12'h514;
  localparam logic [11:0] OFS_RATIO     = 12'h518;
  localparam logic [11:0] OFS_SAMPLE_WIDTH_SELECT    = 12'h51c;
  localparam logic [11:0] OFS_RXPTR     = 12'h538;
  localparam logic [11:0] OFS_TXPTR     = 12'h540;
  localparam logic [11:0] OFS_BUFFER_WORD_COUNT    = 12'h550;
  // event bit positions, shared by event status and irq enable
  localparam int          EV_RXUPD_BIT  = 1;
  localparam int          EV_STOP_BIT   = 2;
  localparam int          EV_TXUPD_BIT  = 5;
  localparam int          EV_W          = 6;
  localparam logic [5:0]  EV_MASK       = 6'h26;
  // reset values
  localparam logic [31:0] RST_MCKDIV    = 32'h20000000;
  localparam logic [3:0]  RST_RATIO     = 4'h6;
  localparam logic [1:0]  RST_SAMPLE_WIDTH_SELECT    = 2'h1;
  localparam logic        RST_TRANSMIT_ENABLE      = 1'b1;
  localparam logic        RST_MASTER_CLOCK_ENABLE     = 1'b1;
  localparam logic        ROLE_MASTER   = 1'b0;
  // timing: system clock and master clock source
  localparam int          CLK_MHZ       = 50;
  localparam int          SRC_MHZ       = 32;
  localparam int          RATIO_CODES   = 9;
  localparam logic [9:0]  RATIO_DIV [RATIO_CODES] = '{
    10'd32, 10'd48, 10'd64, 10'd96, 10'd128, 10'd192, 10'd256, 10'd384, 10'd512};

  typedef struct packed {
    logic sckRise;
    logic sckFall;
    logic frameStart;
  } asp_edges_t;
endpackage

// File: hw/asp_mck_gen.sv
// master clock generator: 32 MHz source rate made from the system clock, then phase divided
`timescale 1ns/1ps
module asp_mck_gen
  import asp_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rstn,
  input  wire logic        run,
  input  wire logic [31:0] freqWord,
  output logic             mck,
  output logic             mckRise
);
  localparam logic [5:0] SRC_STEP = 6'(SRC_MHZ);
  localparam logic [5:0] CLK_MOD  = 6'(CLK_MHZ);

  logic [5:0]  srcAcc_r;
  logic        srcTick;
  logic [31:0] phase_r;
  logic [31:0] phaseNxt;

  // a fractional step keeps the source rate exact on average, at the cost of some jitter
  // one extra bit so the sum cannot wrap before the compare
  assign srcTick  = ({1'b0, srcAcc_r} + {1'b0, SRC_STEP}) >= {1'b0, CLK_MOD};
  assign phaseNxt = phase_r + freqWord;

  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      srcAcc_r <= 6'h00;
    end else if (srcTick) begin
      srcAcc_r <= srcAcc_r + SRC_STEP - CLK_MOD;
    end else begin
      srcAcc_r <= srcAcc_r + SRC_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      phase_r <= 32'h00000000;
      mck     <= 1'b0;
      mckRise <= 1'b0;
    end else begin
      mckRise <= 1'b0;
      if (srcTick) begin
        phase_r <= phaseNxt;
        mck     <= phaseNxt[31];
        mckRise <= phaseNxt[31] & ~phase_r[31];
      end
    end
  end
endmodule

// File: hw/asp_frame_gen.sv
// bit and frame clock generator for master role, counted in master clock periods
`timescale 1ns/1ps
module asp_frame_gen
  import asp_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       run,
  input  wire logic       mckRise,
  input  wire logic [3:0] ratioCode,
  output asp_edges_t      edges,
  output logic            sck,
  output logic            frame_select_clock
);
  logic [9:0] div;
  logic [9:0] cnt_r;

  // unlisted codes fall back to the reset ratio
  assign div = (ratioCode < 4'(RATIO_CODES)) ? RATIO_DIV[ratioCode] : RATIO_DIV[RST_RATIO];

  always_ff @(posedge clock) begin
    if (!rstn || !run) begin
      cnt_r <= 10'h000;
      sck   <= 1'b0;
      frame_select_clock  <= 1'b0;
      edges <= '0;
    end else begin
      edges <= '0;
      if (mckRise) begin
        cnt_r         <= (cnt_r >= div - 10'h001) ? 10'h000 : cnt_r + 10'h001;
        frame_select_clock          <= (cnt_r >= div - 10'h001) ? 1'b0 : (cnt_r + 10'h001 >= (div >> 1));
        sck           <= ~sck;
        edges.sckRise <= ~sck;
        edges.sckFall <= sck;
        edges.frameStart <= (cnt_r >= div - 10'h001);
      end
    end
  end
endmodule

// File: hw/asp_ctrl.sv
// audio serial port: registers, tasks, events, pins and sample shifting
//
// Operation
// - tx pointer update irq needs its enable
// - clear register write one disables irq
// - module works only while enable holds one
// - receive disabled writes no received words
// - master clock enable runs generator, drives pin
// - master clock is 32 MHz over divisor
// - frame clock is master clock over ratio
// - start task begins transfer and generator
// - stop task halts all, raises stopped event
// - pointer copied, update event per buffer count
// - enabled module owns pins and directions
`timescale 1ns/1ps
module asp_ctrl
  import asp_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata,
  output logic                   irq,
  input  wire logic [31:0]       txWord,
  output logic                   txTake,
  output logic      [31:0]       rxWord,
  output logic                   rxValid,
  output logic      [31:0]       txBufAddr,
  output logic      [31:0]       rxBufAddr,
  output logic      [1:0]        sampleWidth,
  output logic                   mckPinOut,
  output logic                   mckPinOeN,
  input  wire logic              sckPinIn,
  output logic                   sckPinOut,
  output logic                   sckPinOeN,
  input  wire logic              lrckPinIn,
  output logic                   lrckPinOut,
  output logic                   lrckPinOeN,
  input  wire logic              sdinPin,
  output logic                   sdoutPinOut,
  output logic                   sdoutPinOeN
);
  logic             enable_r;
  logic             role_r;
  logic             receive_enable_r;
  logic             transmit_enable_r;
  logic             master_clock_enable_r;
  logic [31:0]      mckDiv_r;
  logic [3:0]       ratio_r;
  logic [1:0]       sample_width_select_r;
  logic [31:0]      rxPtr_r;
  logic [31:0]      txPtr_r;
  logic [CNT_W-1:0] buffer_word_count_r;
  logic [EV_W-1:0]  ien_r;
  logic [EV_W-1:0]  ev_r;
  logic [EV_W-1:0]  evSet;
  logic             running_r;
  logic             active;
  logic             genRun;
  logic             wrHit;
  logic             startTask;
  logic             stopTask;

  logic             mckLvl;
  logic             mckRise;
  asp_edges_t       genEdges;
  asp_edges_t       edges;
  logic             genSck;
  logic             genLrck;

  logic [2:0]       sckSync_r;
  logic [2:0]       lrckSync_r;
  logic [1:0]       sdinSync_r;

  logic [31:0]      rxShift_r;
  logic [31:0]      txShift_r;
  logic [CNT_W-1:0] rxCnt_r;
  logic [CNT_W-1:0] txCnt_r;
  logic             rxWrap;
  logic             txWrap;
  logic             rxTake;
  logic             txLoad;

  assign wrHit     = regWr;
  assign startTask = wrHit && regAddr == OFS_START && regWdata[0];
  assign stopTask  = wrHit && regAddr == OFS_STOP && regWdata[0];
  assign active    = enable_r & running_r;
  assign genRun    = active & master_clock_enable_r;

  // configuration registers
  always_ff @(posedge clock) begin
    if (!rstn) begin
      enable_r <= 1'b0;
      role_r   <= ROLE_MASTER;
      receive_enable_r   <= 1'b0;
      transmit_enable_r   <= RST_TRANSMIT_ENABLE;
      master_clock_enable_r  <= RST_MASTER_CLOCK_ENABLE;
      mckDiv_r <= RST_MCKDIV;
      ratio_r  <= RST_RATIO;
      sample_width_select_r <= RST_SAMPLE_WIDTH_SELECT;
      rxPtr_r  <= 32'h00000000;
      txPtr_r  <= 32'h00000000;
      buffer_word_count_r <= '0;
    end else if (wrHit) begin
      unique case (regAddr)
        OFS_ENABLE: enable_r <= regWdata[0];
        OFS_ROLE:   role_r   <= regWdata[0];
        OFS_RECEIVE_ENABLE:   receive_enable_r   <= regWdata[0];
        OFS_TRANSMIT_ENABLE:   transmit_enable_r   <= regWdata[0];
        OFS_MASTER_CLOCK_ENABLE:  master_clock_enable_r  <= regWdata[0];
        OFS_MCKDIV: mckDiv_r <= regWdata;
        OFS_RATIO:  ratio_r  <= regWdata[3:0];
        OFS_SAMPLE_WIDTH_SELECT: sample_width_select_r <= regWdata[1:0];
        OFS_RXPTR:  rxPtr_r  <= regWdata;
        OFS_TXPTR:  txPtr_r  <= regWdata;
        OFS_BUFFER_WORD_COUNT: buffer_word_count_r <= regWdata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // interrupt enable word, plus set and clear aliases
  always_ff @(posedge clock) begin
    if (!rstn) begin
      ien_r <= '0;
    end else if (wrHit) begin
      if (regAddr == OFS_IRQ_WORD) begin
        ien_r <= regWdata[EV_W-1:0] & EV_MASK;
      end else if (regAddr == OFS_IRQ_SET) begin
        ien_r <= ien_r | (regWdata[EV_W-1:0] & EV_MASK);
      end else if (regAddr == OFS_IRQ_CLR) begin
        ien_r <= ien_r & ~regWdata[EV_W-1:0];
      end
    end
  end

  // run state from the start and stop tasks
  always_ff @(posedge clock) begin
    if (!rstn || !enable_r) begin
      running_r <= 1'b0;
    end else if (stopTask) begin
      running_r <= 1'b0;
    end else if (startTask) begin
      running_r <= 1'b1;
    end
  end

  // events: hardware set wins over a software clear in the same cycle
  always_comb begin
    evSet                = '0;
    evSet[EV_RXUPD_BIT]  = rxWrap;
    evSet[EV_TXUPD_BIT]  = txWrap;
    evSet[EV_STOP_BIT]   = stopTask && running_r;
  end

  always_ff @(posedge clock) begin
    if (!rstn) begin
      ev_r <= '0;
    end else begin
      ev_r[EV_RXUPD_BIT] <= evSet[EV_RXUPD_BIT]
        | (ev_r[EV_RXUPD_BIT] & ~(wrHit && regAddr == OFS_EV_RXUPD && regWdata[0]));
      ev_r[EV_STOP_BIT]  <= evSet[EV_STOP_BIT]
        | (ev_r[EV_STOP_BIT] & ~(wrHit && regAddr == OFS_EV_STOP && regWdata[0]));
      ev_r[EV_TXUPD_BIT] <= evSet[EV_TXUPD_BIT]
        | (ev_r[EV_TXUPD_BIT] & ~(wrHit && regAddr == OFS_EV_TXUPD && regWdata[0]));
    end
  end

  // one level output, gated per event by the enable word
  always_ff @(posedge clock) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_r & ien_r);
    end
  end

  // read port, data in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rstn) begin
      regRdata <= 32'h00000000;
    end else if (regRd) begin
      unique case (regAddr)
        OFS_EV_RXUPD: regRdata <= {31'h0, ev_r[EV_RXUPD_BIT]};
        OFS_EV_STOP:  regRdata <= {31'h0, ev_r[EV_STOP_BIT]};
        OFS_EV_TXUPD: regRdata <= {31'h0, ev_r[EV_TXUPD_BIT]};
        OFS_IRQ_WORD,
        OFS_IRQ_SET,
        OFS_IRQ_CLR:  regRdata <= {26'h0, ien_r};
        OFS_ENABLE:   regRdata <= {31'h0, enable_r};
        OFS_ROLE:     regRdata <= {31'h0, role_r};
        OFS_RECEIVE_ENABLE:     regRdata <= {31'h0, receive_enable_r};
        OFS_TRANSMIT_ENABLE:     regRdata <= {31'h0, transmit_enable_r};
        OFS_MASTER_CLOCK_ENABLE:    regRdata <= {31'h0, master_clock_enable_r};
        OFS_MCKDIV:   regRdata <= mckDiv_r;
        OFS_RATIO:    regRdata <= {28'h0, ratio_r};
        OFS_SAMPLE_WIDTH_SELECT:   regRdata <= {30'h0, sample_width_select_r};
        OFS_RXPTR:    regRdata <= rxPtr_r;
        OFS_TXPTR:    regRdata <= txPtr_r;
        OFS_BUFFER_WORD_COUNT:   regRdata <= {{(32-CNT_W){1'b0}}, buffer_word_count_r};
        default:      regRdata <= 32'h00000000;
      endcase
    end
  end

  asp_mck_gen u_mck (
    .clock    (clock),
    .rstn     (rstn),
    .run      (genRun),
    .freqWord (mckDiv_r),
    .mck      (mckLvl),
    .mckRise  (mckRise)
  );

  // in slave role the bit and frame clocks come from the pins, so the generator idles
  asp_frame_gen u_frame (
    .clock     (clock),
    .rstn      (rstn),
    .run       (genRun && role_r == ROLE_MASTER),
    .mckRise   (mckRise),
    .ratioCode (ratio_r),
    .edges     (genEdges),
    .sck       (genSck),
    .frame_select_clock      (genLrck)
  );

  // pin synchronisers; only the second and third stages are looked at
  always_ff @(posedge clock) begin
    if (!rstn) begin
      sckSync_r  <= 3'h0;
      lrckSync_r <= 3'h0;
      sdinSync_r <= 2'h0;
    end else begin
      sckSync_r  <= {sckSync_r[1:0], sckPinIn};
      lrckSync_r <= {lrckSync_r[1:0], lrckPinIn};
      sdinSync_r <= {sdinSync_r[0], sdinPin};
    end
  end

  always_comb begin
    if (role_r == ROLE_MASTER) begin
      edges = genEdges;
    end else begin
      edges.sckRise    = sckSync_r[1] & ~sckSync_r[2];
      edges.sckFall    = ~sckSync_r[1] & sckSync_r[2];
      edges.frameStart = ~lrckSync_r[1] & lrckSync_r[2];
    end
  end

  assign rxTake = active && edges.frameStart && receive_enable_r;
  assign txLoad = active && edges.frameStart && transmit_enable_r;
  assign rxWrap = rxTake && (rxCnt_r + 1'b1 >= buffer_word_count_r);
  assign txWrap = txLoad && (txCnt_r + 1'b1 >= buffer_word_count_r);

  // serial shifting: sample on bit clock rise, launch on fall, one word per frame
  always_ff @(posedge clock) begin
    if (!rstn || !active) begin
      rxShift_r   <= 32'h00000000;
      txShift_r   <= 32'h00000000;
      sdoutPinOut <= 1'b0;
    end else begin
      if (edges.sckRise) begin
        rxShift_r <= {rxShift_r[30:0], sdinSync_r[1]};
      end
      if (txLoad) begin
        txShift_r <= txWord;
      end else if (edges.sckFall) begin
        sdoutPinOut <= txShift_r[31];
        txShift_r   <= {txShift_r[30:0], 1'b0};
      end
    end
  end

  // word hand-off to the memory side and buffer counting
  always_ff @(posedge clock) begin
    if (!rstn) begin
      rxWord  <= 32'h00000000;
      rxValid <= 1'b0;
      txTake  <= 1'b0;
      rxCnt_r <= '0;
      txCnt_r <= '0;
    end else begin
      rxValid <= rxTake;
      txTake  <= txLoad;
      if (rxTake) begin
        rxWord <= rxShift_r;
      end
      if (startTask || rxWrap) begin
        rxCnt_r <= '0;
      end else if (rxTake) begin
        rxCnt_r <= rxCnt_r + 1'b1;
      end
      if (startTask || txWrap) begin
        txCnt_r <= '0;
      end else if (txLoad) begin
        txCnt_r <= txCnt_r + 1'b1;
      end
    end
  end

  // working pointers: copied at start for each enabled direction and again at every buffer boundary
  always_ff @(posedge clock) begin
    if (!rstn) begin
      txBufAddr <= 32'h00000000;
      rxBufAddr <= 32'h00000000;
    end else begin
      if ((startTask && transmit_enable_r) || txWrap) begin
        txBufAddr <= txPtr_r;
      end
      if ((startTask && receive_enable_r) || rxWrap) begin
        rxBufAddr <= rxPtr_r;
      end
    end
  end

  // pin ownership and direction while enabled; released pins read as undriven
  always_ff @(posedge clock) begin
    if (!rstn) begin
      mckPinOut   <= 1'b0;
      mckPinOeN   <= 1'b1;
      sckPinOut   <= 1'b0;
      sckPinOeN   <= 1'b1;
      lrckPinOut  <= 1'b0;
      lrckPinOeN  <= 1'b1;
      sdoutPinOeN <= 1'b1;
      sampleWidth <= RST_SAMPLE_WIDTH_SELECT;
    end else begin
      mckPinOut   <= mckLvl;
      mckPinOeN   <= ~(enable_r & master_clock_enable_r);
      sckPinOut   <= genSck;
      sckPinOeN   <= ~(enable_r && role_r == ROLE_MASTER);
      lrckPinOut  <= genLrck;
      lrckPinOeN  <= ~(enable_r && role_r == ROLE_MASTER);
      sdoutPinOeN <= ~enable_r;
      sampleWidth <= sample_width_select_r;
    end
  end
endmodule

// File: tb/asp_ctrl_properties.sv
// port-level assertions for the audio serial port control block
`timescale 1ns/1ps
module asp_ctrl_checker
  import asp_pkg::*;
(
  input wire logic              clock,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWdata,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [DATA_W-1:0] regRdata,
  input wire logic              irq,
  input wire logic              txTake,
  input wire logic              rxValid,
  input wire logic              mckPinOut,
  input wire logic              mckPinOeN,
  input wire logic              sckPinOeN,
  input wire logic              lrckPinOeN,
  input wire logic              sdoutPinOeN
);
  logic       en_r;
  logic       role_r;
  logic       receive_enable_r;
  logic       master_clock_enable_r;
  logic [5:0] ie_r;
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // shadow of the control bits, rebuilt from the bus writes alone
  always_ff @(posedge clock) begin
    if (!rstn) begin
      {en_r, role_r, receive_enable_r, master_clock_enable_r} <= 4'h1;
      ie_r <= 6'h00;
    end else if (regWr) begin
      case (regAddr)
        OFS_ENABLE: en_r <= regWdata[0];
        OFS_ROLE: role_r <= regWdata[0];
        OFS_RECEIVE_ENABLE: receive_enable_r <= regWdata[0];
        OFS_MASTER_CLOCK_ENABLE: master_clock_enable_r <= regWdata[0];
        OFS_IRQ_WORD: ie_r <= regWdata[5:0] & EV_MASK;
        OFS_IRQ_SET: ie_r <= ie_r | (regWdata[5:0] & EV_MASK);
        OFS_IRQ_CLR: ie_r <= ie_r & ~regWdata[5:0];
        default: ;
      endcase
    end
  end
  property p_ien_rd;
    regRd && (regAddr == OFS_IRQ_SET || regAddr == OFS_IRQ_CLR)
      |=> regRdata == {26'h0, $past(ie_r)};
  endproperty
  a_ien_rd: assert property (p_ien_rd) else $error("irq enable readback wrong");
  property p_irq_mask; (ie_r == 6'h00) [*2] |-> !irq; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq with no enable");
  property p_off_pins;
    (!en_r) [*3] |-> mckPinOeN && sckPinOeN && lrckPinOeN && sdoutPinOeN;
  endproperty
  a_off_pins: assert property (p_off_pins) else $error("pin driven while off");
  property p_mck_off; (!master_clock_enable_r) [*3] |-> mckPinOeN; endproperty
  a_mck_off: assert property (p_mck_off) else $error("mck pin not released");
  property p_slave; (en_r && role_r) [*3] |-> sckPinOeN && lrckPinOeN; endproperty
  a_slave: assert property (p_slave) else $error("clock pins driven in slave role");
  property p_own;
    (en_r && !role_r) [*3] |-> !(sckPinOeN || lrckPinOeN || sdoutPinOeN);
  endproperty
  a_own: assert property (p_own) else $error("master pins not driven");
  property p_rx_off; (!receive_enable_r) [*3] |-> !rxValid; endproperty
  a_rx_off: assert property (p_rx_off) else $error("word received while off");
  property p_pulse; txTake |=> !txTake; endproperty
  a_pulse: assert property (p_pulse) else $error("two words in one frame");
  property p_start;
    regWr && regAddr == OFS_START && regWdata[0] && en_r && master_clock_enable_r
      |-> ##[1:300] $changed(mckPinOut);
  endproperty
  a_start: assert property (p_start) else $error("mck idle after start");
  c_irq: cover property (irq);
  c_rx: cover property (rxValid);
  c_tx: cover property (txTake);
endmodule

bind asp_ctrl asp_ctrl_checker u_chk (
  .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
  .regRd(regRd), .regRdata(regRdata), .irq(irq), .txTake(txTake), .rxValid(rxValid),
  .mckPinOut(mckPinOut), .mckPinOeN(mckPinOeN), .sckPinOeN(sckPinOeN),
  .lrckPinOeN(lrckPinOeN), .sdoutPinOeN(sdoutPinOeN));

// File: tb/asp_codec_model.sv
// behavioural codec: slave-role bit and frame clocks plus a serial data pattern
`timescale 1ns/1ps
module asp_codec_model (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic drive,
  input  wire logic sckSeen,
  output logic      sck,
  output logic      frame_select_clock,
  output logic      sdin
);
  logic [8:0]  cnt_r;
  logic [31:0] pat_r;
  logic        sckDly_r;
  // clocks stand low outside a run so no stray frame start appears
  assign sck  = drive & cnt_r[2];
  assign frame_select_clock = drive & cnt_r[8];
  assign sdin = pat_r[31];
  always_ff @(posedge clock) begin
    if (!rstn || !drive) cnt_r <= 9'h000;
    else cnt_r <= cnt_r + 9'h001;
  end
  // data moves on every bit clock fall, so it never holds a stale level
  always_ff @(posedge clock) begin
    sckDly_r <= sckSeen;
    if (!rstn) pat_r <= 32'hc3a5_1e69;
    else if (sckDly_r && !sckSeen) pat_r <= {pat_r[30:0], pat_r[31]};
  end
endmodule

// File: tb/tb.sv
// self-checking bench of the audio serial port control block
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb;
  import asp_pkg::*;
  logic              clock = 1'b0;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0;
  logic              regWr = 1'b0;
  logic              regRd = 1'b0;
  logic              drive = 1'b0;
  logic [31:0]       txWord = 32'h5a0f_c369;
  logic [DATA_W-1:0] regRdata;
  logic [31:0]       txBufAddr;
  logic [31:0]       rxBufAddr;
  logic [1:0]        sampleWidth;
  logic              irq, txTake, rxValid, mckPinOut, mckPinOeN, sckPinOut, sckPinOeN;
  logic              lrckPinOut, lrckPinOeN, sdoutPinOeN, codSck, codLrck, codSdin;
  logic              sckW, lrckW;
  logic [4:0]        mon;
  int                error_cnt = 0;
  int                check_count = 0;
  assign sckW  = !sckPinOeN ? sckPinOut : codSck;
  assign lrckW = !lrckPinOeN ? lrckPinOut : codLrck;
  assign mon   = {irq, rxValid, txTake, lrckW, mckPinOut};
  always #10 clock = ~clock;
  asp_ctrl DUT (
    .clock(clock), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .irq(irq), .txWord(txWord), .txTake(txTake),
    .rxWord(), .rxValid(rxValid), .txBufAddr(txBufAddr), .rxBufAddr(rxBufAddr),
    .sampleWidth(sampleWidth), .mckPinOut(mckPinOut), .mckPinOeN(mckPinOeN),
    .sckPinIn(sckW), .sckPinOut(sckPinOut), .sckPinOeN(sckPinOeN), .lrckPinIn(lrckW),
    .lrckPinOut(lrckPinOut), .lrckPinOeN(lrckPinOeN), .sdinPin(codSdin), .sdoutPinOut(),
    .sdoutPinOeN(sdoutPinOeN));
  asp_codec_model u_cod (.clock(clock), .rstn(rstn), .drive(drive), .sckSeen(sckW),
    .sck(codSck), .frame_select_clock(codLrck), .sdin(codSdin));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    @(posedge clock);
    `CHK(regRdata, e)
  endtask
  task automatic rises(input int n, input int s, output int r);
    logic p;
    p = mon[s];
    r = 0;
    repeat (n) begin
      @(posedge clock);
      if (mon[s] === 1'b1 && p === 1'b0) r++;
      p = mon[s];
    end
  endtask
  task automatic t_reset();
    logic [11:0] ofs [11] = '{OFS_IRQ_SET, OFS_IRQ_CLR, OFS_ENABLE, OFS_ROLE, OFS_RECEIVE_ENABLE,
      OFS_TRANSMIT_ENABLE, OFS_MASTER_CLOCK_ENABLE, OFS_MCKDIV, OFS_RATIO, OFS_SAMPLE_WIDTH_SELECT, 12'h7fc};
    logic [31:0] val [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1, 32'h1,
      32'h2000_0000, 32'h6, 32'h1, 32'h0};
    foreach (ofs[i]) rdc(ofs[i], val[i]);
    `CHK({mckPinOeN, sckPinOeN, lrckPinOeN, sdoutPinOeN, sampleWidth}, 6'h3d)
  endtask
  task automatic t_irq_en();
    wr(OFS_IRQ_WORD, 32'hff);
    rdc(OFS_IRQ_WORD, 32'h26);
    wr(OFS_IRQ_CLR, 32'h26);
    wr(OFS_IRQ_SET, 32'h26);
    rdc(OFS_IRQ_SET, 32'h26);
    wr(OFS_IRQ_CLR, 32'h4);
    rdc(OFS_IRQ_CLR, 32'h22);
    wr(OFS_IRQ_SET, 32'h0);
    wr(OFS_IRQ_CLR, 32'h0);
    rdc(OFS_IRQ_SET, 32'h22);
    wr(OFS_IRQ_CLR, 32'h22);
    rdc(OFS_IRQ_CLR, 32'h0);
  endtask
  task automatic t_master();
    logic [31:0] dv [3] = '{32'h8000_0000, 32'h2000_0000, 32'h020c_0000};
    int          ex [3] = '{1024, 256, 16};
    int          r;
    int          e;
    wr(OFS_TXPTR, 32'h2000_0100);
    wr(OFS_RXPTR, 32'h2000_0800);
    wr(OFS_BUFFER_WORD_COUNT, 32'h2);
    wr(OFS_MCKDIV, 32'h8000_0000);
    wr(OFS_RATIO, 32'h0);
    wr(OFS_ENABLE, 32'h1);
    wr(OFS_START, 32'h1);
    cyc(3);
    `CHK({txBufAddr, rxBufAddr}, {32'h2000_0100, 32'h0})
    `CHK({mckPinOeN, sckPinOeN, lrckPinOeN, sdoutPinOeN}, 4'h0)
    rises(1000, 3, r);
    `CHK(r, 0)
    rises(1000, 2, r);
    `CHK(r >= 9 && r <= 11, 1'b1)
    `CHK(irq, 1'b0)
    rdc(OFS_EV_TXUPD, 32'h1);
    wr(OFS_IRQ_SET, 32'h20);
    cyc(2);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_CLR, 32'h20);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(OFS_RECEIVE_ENABLE, 32'h1);
    rises(1000, 3, r);
    `CHK(r >= 9 && r <= 11, 1'b1)
    `CHK(rxBufAddr, 32'h2000_0800)
    // old frame may run up to 1600 cycles, so each window starts after it
    for (int i = 0; i < RATIO_CODES; i++) begin
      wr(OFS_RATIO, 32'(i));
      cyc(1700);
      rises(3200, 1, r);
      e = 1024 / int'(RATIO_DIV[i]);
      `CHK(r >= e - 1 && r <= e + 1, 1'b1)
    end
    foreach (dv[i]) begin
      wr(OFS_MCKDIV, dv[i]);
      cyc(300);
      rises(3200, 0, r);
      `CHK(r >= ex[i] - 1 && r <= ex[i] + 1, 1'b1)
    end
  endtask
  task automatic t_stop();
    int r;
    wr(OFS_IRQ_SET, 32'h4);
    wr(OFS_STOP, 32'h1);
    rdc(OFS_EV_STOP, 32'h1);
    `CHK(irq, 1'b1)
    rises(400, 0, r);
    `CHK(r, 0)
    wr(OFS_EV_STOP, 32'h1);
    wr(OFS_MASTER_CLOCK_ENABLE, 32'h0);
    cyc(2);
    `CHK({irq, mckPinOeN}, 2'h1)
  endtask
  task automatic t_slave();
    int r;
    wr(OFS_ENABLE, 32'h0);
    wr(OFS_ROLE, 32'h1);
    wr(OFS_ENABLE, 32'h1);
    drive <= 1'b1;
    wr(OFS_START, 32'h1);
    cyc(3);
    `CHK({sckPinOeN, lrckPinOeN}, 2'h3)
    rises(1100, 3, r);
    `CHK(r >= 1 && r <= 3, 1'b1)
    wr(OFS_STOP, 32'h1);
    drive <= 1'b0;
    wr(OFS_ENABLE, 32'h0);
    cyc(3);
    `CHK({mckPinOeN, sckPinOeN, lrckPinOeN, sdoutPinOeN}, 4'hf)
    rises(400, 2, r);
    `CHK(r, 0)
  endtask
  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(8);
    rstn <= 1'b1;
    @(posedge clock);
    t_reset();
    t_irq_en();
    t_master();
    t_stop();
    t_slave();
    print_verdict();
  end
  initial begin
    cyc(100000);
    error_cnt++;
    print_verdict();
  end
endmodule
